/* File: hdl/imuaux_regs.vh */
// Register offsets, field positions and timing counts of the auxiliary output block
`ifndef IMUAUX_REGS_VH
`define IMUAUX_REGS_VH
`define IMUAUX_OFS_TEMP 8'h1c
`define IMUAUX_OFS_STAMP 8'h1e
`define IMUAUX_OFS_CNTR 8'h22
`define IMUAUX_OFS_ANG_XL 8'h24
`define IMUAUX_OFS_ANG_XH 8'h26
`define IMUAUX_OFS_ANG_YL 8'h28
`define IMUAUX_OFS_ANG_YH 8'h2a
`define IMUAUX_OFS_ANG_ZL 8'h2c
`define IMUAUX_OFS_ANG_ZH 8'h2e
`define IMUAUX_OFS_VEL_XL 8'h30
`define IMUAUX_OFS_VEL_XH 8'h32
`define IMUAUX_OFS_VEL_YL 8'h34
`define IMUAUX_OFS_VEL_YH 8'h36
`define IMUAUX_OFS_VEL_ZL 8'h38
`define IMUAUX_OFS_VEL_ZH 8'h3a
`define IMUAUX_OFS_MISC 8'h60
`define IMUAUX_OFS_DEC 8'h64
`define IMUAUX_OFS_CMD 8'h68
`define IMUAUX_SYNC_LSB 2
`define IMUAUX_SYNC_MSB 4
`define IMUAUX_SYNC_SCALED 3'h2
`define IMUAUX_CMD_RESET_BIT 7
`define IMUAUX_MISC_RESET 16'h0000
`define IMUAUX_DEC_RESET 16'h0000
`define IMUAUX_STAMP_NS 49020
`define IMUAUX_CLK_NS 10
`define IMUAUX_STAMP_CYC ((`IMUAUX_STAMP_NS) / (`IMUAUX_CLK_NS))
`define IMUAUX_SAMPLE_SPS 2000
`define IMUAUX_SAMPLE_CYC ((1000000000 / `IMUAUX_SAMPLE_SPS) / `IMUAUX_CLK_NS)
`endif

/* File: hdl/imuaux_fifo.v */
// Small valid/ready FIFO carrying sensor sample words
`timescale 1ns/10ps
module imuaux_fifo #(
	parameter WIDTH = 96,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst_b,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign do_wr = in_valid & in_ready;
	assign do_rd = out_valid & out_ready;
	always @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1 + {AW{1'b0}}) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1 + {AW{1'b0}}) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (do_wr & ~do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd & ~do_wr) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // imuaux_fifo

/* File: hdl/imuaux_top.v */
// Temperature, sync time stamp, update counter and delta angle/velocity outputs
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "imuaux_regs.vh"
module imuaux_top #(
	parameter SAMPLE_CYC = `IMUAUX_SAMPLE_CYC,
	parameter STAMP_CYC = `IMUAUX_STAMP_CYC,
	parameter SCALE_SHIFT = 4
) (
	input wire CORE_CLK,
	input wire RST_B,
	input wire [7:0] ADDR,
	input wire [15:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [15:0] RDATA,
	input wire SYNC_PIN,
	input wire [15:0] TEMP_IN,
	input wire [15:0] GYRO_X,
	input wire [15:0] GYRO_Y,
	input wire [15:0] GYRO_Z,
	input wire [15:0] ACCL_X,
	input wire [15:0] ACCL_Y,
	input wire [15:0] ACCL_Z,
	input wire SAMPLE_VALID,
	output reg SAMPLE_READY,
	output reg DATA_READY_PIN
);
	localparam W = 96;
	localparam ST_IDLE = 3'b001;
	localparam ST_ACC = 3'b010;
	localparam ST_LOAD = 3'b100;

	// ****************************************
	// Helpers
	// ****************************************
	function [31:0] pair_sum;
		input [15:0] cur;
		input [15:0] prev;
		begin
			pair_sum = {{16{cur[15]}}, cur} + {{16{prev[15]}}, prev};
		end
	endfunction

	function [15:0] sel16;
		input [15:0] a;
		input [15:0] b;
		input hi;
		begin
			sel16 = hi ? a : b;
		end
	endfunction

	// ****************************************
	// Sync pin synchroniser and edge detect
	// ****************************************
	reg sync_m;
	reg sync_s;
	reg sync_d;
	wire sync_edge;
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync_m <= 1'b0;
			sync_s <= 1'b0;
			sync_d <= 1'b0;
		end else begin
			sync_m <= SYNC_PIN;
			sync_s <= sync_m;
			sync_d <= sync_s;
		end
	end
	assign sync_edge = sync_s & ~sync_d;

	// ****************************************
	// Control registers
	// ****************************************
	reg [15:0] misc_ctrl;
	reg [15:0] dec_setting;
	reg soft_reset;
	wire scaled_mode;
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			misc_ctrl <= `IMUAUX_MISC_RESET;
			dec_setting <= `IMUAUX_DEC_RESET;
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= WR && (ADDR == `IMUAUX_OFS_CMD) && WDATA[`IMUAUX_CMD_RESET_BIT];
			if (WR && ADDR == `IMUAUX_OFS_MISC) begin
				misc_ctrl <= WDATA;
			end
			if (WR && ADDR == `IMUAUX_OFS_DEC) begin
				dec_setting <= WDATA;
			end
		end
	end
	assign scaled_mode = (misc_ctrl[`IMUAUX_SYNC_MSB:`IMUAUX_SYNC_LSB] == `IMUAUX_SYNC_SCALED);

	// ****************************************
	// Time stamp counter
	// ****************************************
	reg [15:0] stamp_pre;
	reg [15:0] stamp_run;
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			stamp_pre <= 16'h0000;
			stamp_run <= 16'h0000;
		end else if (!scaled_mode || sync_edge) begin
			stamp_pre <= 16'h0000;
			stamp_run <= 16'h0000;
		end else if (stamp_pre == STAMP_CYC[15:0] - 16'h0001) begin
			stamp_pre <= 16'h0000;
			stamp_run <= stamp_run + 16'h0001;
		end else begin
			stamp_pre <= stamp_pre + 16'h0001;
		end
	end

	// ****************************************
	// Internal sample clock and input FIFO
	// ****************************************
	reg [15:0] tick_cnt;
	reg sample_tick;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [W-1:0] fifo_out_data;
	reg fifo_pop;
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tick_cnt <= 16'h0000;
			sample_tick <= 1'b0;
			SAMPLE_READY <= 1'b0;
		end else begin
			sample_tick <= (tick_cnt == SAMPLE_CYC[15:0] - 16'h0001);
			tick_cnt <= (tick_cnt == SAMPLE_CYC[15:0] - 16'h0001) ? 16'h0000 : tick_cnt + 16'h0001;
			// Drop after each take, so a full FIFO is never offered a word through the flop lag
			SAMPLE_READY <= fifo_in_ready & ~(SAMPLE_VALID & SAMPLE_READY);
		end
	end

	imuaux_fifo #(
		.WIDTH(W),
		.DEPTH(4),
		.AW(2)
	) u_fifo (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.in_valid(SAMPLE_VALID & SAMPLE_READY),
		.in_ready(fifo_in_ready),
		.in_data({GYRO_X, GYRO_Y, GYRO_Z, ACCL_X, ACCL_Y, ACCL_Z}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// ****************************************
	// Trapezoidal integration
	// ****************************************
	reg [2:0] state;
	reg [15:0] left;
	reg [15:0] prev [0:5];
	reg [31:0] acc [0:5];
	reg [31:0] out_acc [0:5];
	reg [15:0] update_counter;
	reg [15:0] sync_time_stamp;
	reg [15:0] internal_temperature;
	wire [15:0] cur [0:5];
	integer i;
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_cur
			assign cur[g] = fifo_out_data[W-1-16*g -: 16];
		end
	endgenerate

	always @* begin
		fifo_pop = (state == ST_ACC) && sample_tick && fifo_out_valid;
	end

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
			left <= 16'h0000;
			update_counter <= 16'h0000;
			sync_time_stamp <= 16'h0000;
			internal_temperature <= 16'h0000;
			DATA_READY_PIN <= 1'b0;
			for (i = 0; i < 6; i = i + 1) begin
				prev[i] <= 16'h0000;
				acc[i] <= 32'h00000000;
				out_acc[i] <= 32'h00000000;
			end
		end else if (soft_reset) begin
			state <= ST_IDLE;
			update_counter <= 16'h0000;
			DATA_READY_PIN <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					left <= dec_setting;
					for (i = 0; i < 6; i = i + 1) begin
						acc[i] <= 32'h00000000;
					end
					state <= ST_ACC;
				end
				ST_ACC: begin
					if (fifo_pop) begin
						for (i = 0; i < 6; i = i + 1) begin
							acc[i] <= acc[i] + pair_sum(cur[i], prev[i]);
							prev[i] <= cur[i];
						end
						if (left == 16'h0000) begin
							state <= ST_LOAD;
						end else begin
							left <= left - 16'h0001;
						end
					end
				end
				ST_LOAD: begin
					for (i = 0; i < 6; i = i + 1) begin
						out_acc[i] <= acc[i] << SCALE_SHIFT;
					end
					sync_time_stamp <= stamp_run;
					internal_temperature <= TEMP_IN;
					update_counter <= update_counter + 16'h0001;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
			DATA_READY_PIN <= (state == ST_LOAD);
		end
	end

	// ****************************************
	// Register read port, writes to outputs ignored
	// ****************************************
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= 16'h0000;
		end else if (RD) begin
			case (ADDR)
				`IMUAUX_OFS_TEMP: RDATA <= internal_temperature;
				`IMUAUX_OFS_STAMP: RDATA <= sync_time_stamp;
				`IMUAUX_OFS_CNTR: RDATA <= update_counter;
				`IMUAUX_OFS_ANG_XL, `IMUAUX_OFS_ANG_XH: RDATA <= sel16(out_acc[0][31:16], out_acc[0][15:0], ADDR[1]);
				`IMUAUX_OFS_ANG_YL, `IMUAUX_OFS_ANG_YH: RDATA <= sel16(out_acc[1][31:16], out_acc[1][15:0], ADDR[1]);
				`IMUAUX_OFS_ANG_ZL, `IMUAUX_OFS_ANG_ZH: RDATA <= sel16(out_acc[2][31:16], out_acc[2][15:0], ADDR[1]);
				`IMUAUX_OFS_VEL_XL, `IMUAUX_OFS_VEL_XH: RDATA <= sel16(out_acc[3][31:16], out_acc[3][15:0], ADDR[1]);
				`IMUAUX_OFS_VEL_YL, `IMUAUX_OFS_VEL_YH: RDATA <= sel16(out_acc[4][31:16], out_acc[4][15:0], ADDR[1]);
				`IMUAUX_OFS_VEL_ZL, `IMUAUX_OFS_VEL_ZH: RDATA <= sel16(out_acc[5][31:16], out_acc[5][15:0], ADDR[1]);
				`IMUAUX_OFS_MISC: RDATA <= misc_ctrl;
				`IMUAUX_OFS_DEC: RDATA <= dec_setting;
				default: RDATA <= 16'h0000;
			endcase
		end else begin
			RDATA <= 16'h0000;
		end
	end
endmodule // imuaux_top

/* File: sim/imuaux_asserts.sv */
// Port assertions for the auxiliary output block
`timescale 1ns/10ps
module imuaux_asserts #(
	parameter SAMPLE_CYC = 20
) (
	input wire CORE_CLK,
	input wire RST_B,
	input wire [7:0] ADDR,
	input wire [15:0] WDATA,
	input wire WR,
	input wire RD,
	input wire [15:0] RDATA,
	input wire DATA_READY_PIN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	int gap;
	logic scaled_seen;
	logic dr_seen;
	// Cycles since last update; any write to 8'h68 preloads a full window, so the next update passes the spacing check
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			gap <= SAMPLE_CYC;
			scaled_seen <= 1'b0;
			dr_seen <= 1'b0;
		end else begin
			gap <= (WR && ADDR == 8'h68) ? SAMPLE_CYC : (DATA_READY_PIN ? 1 : gap + 1);
			dr_seen <= dr_seen | DATA_READY_PIN;
			scaled_seen <= scaled_seen | (WR && ADDR == 8'h60 && WDATA[4:2] == 3'h2);
		end
	end
	sequence cmd_reset;
		WR && ADDR == 8'h68 && WDATA[7];
	endsequence
	sequence cntr_read;
		RD && ADDR == 8'h22;
	endsequence
	AST_DR_SINGLE: assert property (DATA_READY_PIN |=> !DATA_READY_PIN)
		else $error("update pulse too long");
	AST_DR_SPACING: assert property (DATA_READY_PIN |-> gap >= SAMPLE_CYC)
		else $error("updates too close");
	AST_RD_IDLE: assert property (!RD |=> RDATA == 16'h0000)
		else $error("read data outside read slot");
	AST_UNMAPPED: assert property (RD && ADDR == 8'h70 |=> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	AST_SOFT_CLEAR: assert property (cmd_reset ##2 cntr_read |=> RDATA <= 16'h0001)
		else $error("counter not cleared by soft reset");
	AST_CNTR_START: assert property (RD && ADDR == 8'h22 && !dr_seen && !DATA_READY_PIN |=> RDATA == 16'h0000)
		else $error("counter not zero before first update");
	AST_STAMP_OFF: assert property (RD && ADDR == 8'h1e && !scaled_seen |=> RDATA == 16'h0000)
		else $error("stamp counts outside scaled mode");
	AST_RST_QUIET: assert property ($rose(RST_B) |-> RDATA == 16'h0000 && !DATA_READY_PIN)
		else $error("outputs busy after reset");
endmodule // imuaux_asserts

/* File: sim/imuaux_src.sv */
// Sample source and sync clock standing in for the sensor front end
`timescale 1ns/10ps
module imuaux_src (
	input wire clk,
	input wire run,
	input wire ready,
	input wire [15:0] word,
	output logic valid,
	output logic [15:0] gyro,
	output logic [15:0] accl,
	output logic sync_pin
);
	wire keep = run | (valid & ~ready);
	initial begin
		valid = 1'b0;
		gyro = 16'h0000;
		accl = 16'h0000;
		sync_pin = 1'b0;
		#3;
		forever #80 sync_pin = run & ~sync_pin;
	end
	// Offered word held until taken; idle words toggle
	always @(posedge clk) begin
		valid <= keep;
		gyro <= keep ? word : ~gyro;
		accl <= keep ? -word : ~accl;
	end
endmodule // imuaux_src

/* File: sim/imuaux_top_tb_top.sv */
// Self-checking bench for the auxiliary output block
`timescale 1ns/10ps
module imuaux_top_tb_top;
	logic clk, rst_b, wr, rd, rd_d, run, lim, valid, ready, drdy, sync_pin;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, temp, word, gyro, accl;
	logic [16:0] expq[$];
	logic signed [31:0] ea;
	int mismatches, samples_checked, cycles, t0;
	imuaux_top #(.SAMPLE_CYC(20), .STAMP_CYC(3)) imuaux_top_inst (.CORE_CLK(clk), .RST_B(rst_b),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SYNC_PIN(sync_pin),
		.TEMP_IN(temp), .GYRO_X(gyro), .GYRO_Y(gyro), .GYRO_Z(gyro), .ACCL_X(accl), .ACCL_Y(accl),
		.ACCL_Z(accl), .SAMPLE_VALID(valid), .SAMPLE_READY(ready), .DATA_READY_PIN(drdy));
	imuaux_src imuaux_src_inst (.clk(clk), .run(run), .ready(ready), .word(word), .valid(valid),
		.gyro(gyro), .accl(accl), .sync_pin(sync_pin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [16:0] e);
		samples_checked++;
		if ((e[16] ? got <= e[15:0] : got === e[15:0]) !== 1'b1) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, e[15:0]);
		end
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
		addr <= a;
		rd <= 1'b1;
		expq.push_back({lim, e});
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_dr(input int n);
		repeat (n) begin
			do @(posedge clk); while (drdy !== 1'b1);
		end
	endtask
	always @(posedge clk) begin
		rd_d <= rd;
		cycles++;
		if (rd_d === 1'b1)
			cmp(rdata, expq.pop_front());
		if (cycles == 3000) begin
			mismatches++;
			$display("[ERR] %0t timeout %h", $time, cycles);
			finish_test();
		end
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		rd_d = 1'b0;
		run = 1'b0;
		lim = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		temp = 16'($urandom(47));
		word = {8'hff, 8'($urandom)};
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd_reg(8'h22, 16'h0000);
		rd_reg(8'h1e, 16'h0000);
		rd_reg(8'h70, 16'h0000);
		wr_reg(8'h22, 16'hffff);
		rd_reg(8'h22, 16'h0000);
		$display("reset test done");
		run <= 1'b1;
		wait_dr(2);
		ea = 32'(signed'(word)) * 32;
		rd_reg(8'h22, 16'h0002);
		rd_reg(8'h24, ea[15:0]);
		rd_reg(8'h26, ea[31:16]);
		ea = -ea;
		rd_reg(8'h30, ea[15:0]);
		rd_reg(8'h32, ea[31:16]);
		rd_reg(8'h1c, temp);
		wait_dr(1);
		t0 = 0;
		do begin
			@(posedge clk);
			t0++;
		end while (drdy !== 1'b1);
		cmp(16'(t0), 17'h00014);
		repeat (8) @(posedge clk);
		cmp({15'h0000, ready}, 17'h00000);
		$display("update test done");
		wr_reg(8'h64, 16'h0001);
		wait_dr(3);
		ea = 32'(signed'(word)) * 64;
		rd_reg(8'h22, 16'h0007);
		rd_reg(8'h2e, ea[31:16]);
		rd_reg(8'h2c, ea[15:0]);
		rd_reg(8'h2a, ea[31:16]);
		rd_reg(8'h28, ea[15:0]);
		ea = -ea;
		rd_reg(8'h3a, ea[31:16]);
		rd_reg(8'h38, ea[15:0]);
		rd_reg(8'h36, ea[31:16]);
		$display("decimation test done");
		wr_reg(8'h60, 16'h0008);
		wait_dr(2);
		lim = 1'b1;
		rd_reg(8'h1e, 16'h0006);
		lim = 1'b0;
		wait_dr(1);
		wr_reg(8'h68, 16'h0080);
		rd_reg(8'h22, 16'h0000);
		run <= 1'b0;
		repeat (160) @(posedge clk);
		cmp({15'h0000, ready}, 17'h00001);
		$display("stamp and soft reset test done");
		finish_test();
	end
endmodule // imuaux_top_tb_top
bind imuaux_top imuaux_asserts #(.SAMPLE_CYC(SAMPLE_CYC)) imuaux_asserts_inst (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DATA_READY_PIN(DATA_READY_PIN));
